// ===== hdl/gsm_meas_cfg.svh
`ifndef GSM_MEAS_CFG_SVH
`define GSM_MEAS_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GSM_ADDR_RATE_HIGH 8'h02
`define GSM_ADDR_RATE_LOW 8'h03
`define GSM_ADDR_MEAS_CONFIG 8'h04
`define GSM_ADDR_RESULT_HIGH 8'h05
`define GSM_ADDR_RESULT_LOW 8'h06
`define GSM_ADDR_MEAS_STATUS 8'h07

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GSM_RST_MEAS_CONFIG 8'h24
`define GSM_RST_RATE_HIGH 4'h0
`define GSM_RST_RATE_LOW 8'h3C
`define GSM_RST_RESULT 16'h0000
`define GSM_RST_OFFSET 16'h0000

// ----------------------------------------
// Field positions and encodings
// ----------------------------------------
`define GSM_MODE_MSB 1
`define GSM_MODE_LSB 0
`define GSM_COMP_MSB 3
`define GSM_COMP_LSB 2
`define GSM_STS_READY_BIT 4
`define GSM_STS_TOP_ZERO 2'h0
`define GSM_MODE_IDLE 2'h0
`define GSM_MODE_SINGLE 2'h1
`define GSM_MODE_CONT 2'h2
`define GSM_COMP_OFF 2'h0
`define GSM_COMP_AUTO 2'h1
`define GSM_COMP_FORCED 2'h2

// ----------------------------------------
// Timing and unmapped read value
// ----------------------------------------
`define GSM_CLK_HZ 50000000
`define GSM_PERIOD_MIN_S 12'h005
`define GSM_UNMAPPED_READ 8'h00

`endif

// ===== hdl/gsm_meas_pkg.sv
package gsm_meas_pkg;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      GSM_IDLE = 3'h1,
      GSM_MEAS = 3'h2,
      GSM_WAIT = 3'h4
   } gsm_state_e;

   // ----------------------------------------
   // Host register request
   // ----------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } gsm_host_req_s;

   // ----------------------------------------
   // Measurement core answer
   // ----------------------------------------
   typedef struct packed {
      logic meas_done;
      logic [15:0] result;
      logic comp_done;
      logic offset_valid;
      logic [15:0] offset;
   } gsm_core_rsp_s;

   // ----------------------------------------
   // Whole module state
   // ----------------------------------------
   typedef struct packed {
      gsm_state_e st;
      logic [7:0] cfg;
      logic [3:0] rate_h;
      logic [7:0] rate_l;
      logic [11:0] period;
      logic [11:0] sec_cnt;
      logic [25:0] tick_cnt;
      logic [15:0] result;
      logic ready;
      logic [15:0] offset;
      logic [7:0] rdata;
      logic meas_start;
      logic comp_force;
      logic auto_en;
   } gsm_regs_s;

endpackage

// ===== hdl/gsm_meas_ctrl.sv
`include "gsm_meas_cfg.svh"

// Function
// - Offset compensation select 00 turns automatic baseline compensation off.
// - Select 01 keeps automatic compensation on and stores every newly computed offset.
// - Writing select 10 forces one compensation, after which hardware sets the field to 01.
// - Writing operating mode 01 starts exactly one measurement.
// - After a single-shot measurement the mode field returns to idle by itself.
// - A new measurement period is taken only on the change from idle to continuous.
// - The result is a 16-bit two's complement ppm value, high byte then low byte.
// - Both result bytes are refreshed at the end of every measurement.
// - Reading the low result byte clears the ready flag; reading the high byte does not.
// - The ready flag at status bit 4 is set at the end of every measurement.
// - Host writes to read-only status bits are ignored.
// - Status bits 7:6 always read as 00.
module gsm_meas_ctrl #(
   parameter int CLK_HZ = `GSM_CLK_HZ
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Host register port
   input wire gsm_meas_pkg::gsm_host_req_s host_req_in,
   output logic [7:0] host_rdata_out,
   // Measurement core
   input wire gsm_meas_pkg::gsm_core_rsp_s core_rsp_in,
   output logic meas_start_out,
   output logic comp_force_out,
   output logic auto_comp_en_out,
   output logic [15:0] offset_out,
   output logic [11:0] period_out
);

   gsm_meas_pkg::gsm_regs_s r_reg;
   gsm_meas_pkg::gsm_regs_s r_next;
   logic [11:0] rate_req;
   logic [1:0] mode_next;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      r_next = r_reg;
      r_next.meas_start = 1'b0;
      r_next.comp_force = 1'b0;
      rate_req = {r_reg.rate_h, r_reg.rate_l};
      mode_next = 2'h0;

      // Reads answer one cycle after the strobe.
      if (host_req_in.rd) begin
         case (host_req_in.addr)
            `GSM_ADDR_RATE_HIGH: r_next.rdata = {4'h0, r_reg.rate_h};
            `GSM_ADDR_RATE_LOW: r_next.rdata = r_reg.rate_l;
            `GSM_ADDR_MEAS_CONFIG: r_next.rdata = r_reg.cfg;
            `GSM_ADDR_RESULT_HIGH: r_next.rdata = r_reg.result[15:8];
            `GSM_ADDR_RESULT_LOW: r_next.rdata = r_reg.result[7:0];
            `GSM_ADDR_MEAS_STATUS: r_next.rdata = {`GSM_STS_TOP_ZERO, 1'b0, r_reg.ready, 4'h0};
            default: r_next.rdata = `GSM_UNMAPPED_READ;
         endcase
      end
      if (host_req_in.rd && host_req_in.addr == `GSM_ADDR_RESULT_LOW) begin
         r_next.ready = 1'b0;
      end

      // Status holds no writable bit here, so a status write falls to the default branch and changes nothing.
      if (host_req_in.wr) begin
         case (host_req_in.addr)
            `GSM_ADDR_RATE_HIGH: r_next.rate_h = host_req_in.wdata[3:0];
            `GSM_ADDR_RATE_LOW: r_next.rate_l = host_req_in.wdata;
            `GSM_ADDR_MEAS_CONFIG: begin
               r_next.cfg = host_req_in.wdata;
               if (host_req_in.wdata[`GSM_COMP_MSB:`GSM_COMP_LSB] == `GSM_COMP_FORCED) begin
                  r_next.comp_force = 1'b1;
               end
            end
            default: r_next.cfg = r_reg.cfg;
         endcase
      end

      // A finished forced compensation hands back to automatic mode.
      if (core_rsp_in.comp_done && r_next.cfg[`GSM_COMP_MSB:`GSM_COMP_LSB] == `GSM_COMP_FORCED) begin
         r_next.cfg[`GSM_COMP_MSB:`GSM_COMP_LSB] = `GSM_COMP_AUTO;
      end
      if (core_rsp_in.offset_valid && r_next.cfg[`GSM_COMP_MSB:`GSM_COMP_LSB] != `GSM_COMP_OFF) begin
         r_next.offset = core_rsp_in.offset;
      end
      // Registered so the enable output comes from a flop and tracks the stored select.
      r_next.auto_en = (r_next.cfg[`GSM_COMP_MSB:`GSM_COMP_LSB] != `GSM_COMP_OFF);

      mode_next = r_next.cfg[`GSM_MODE_MSB:`GSM_MODE_LSB];
      case (r_reg.st)
         gsm_meas_pkg::GSM_IDLE: begin
            if (mode_next == `GSM_MODE_SINGLE) begin
               r_next.meas_start = 1'b1;
               r_next.st = gsm_meas_pkg::GSM_MEAS;
            end else if (mode_next == `GSM_MODE_CONT) begin
               // Short periods are raised to the floor so the core is never restarted too soon.
               r_next.period = (rate_req < `GSM_PERIOD_MIN_S) ? `GSM_PERIOD_MIN_S : rate_req;
               r_next.meas_start = 1'b1;
               r_next.st = gsm_meas_pkg::GSM_MEAS;
            end
         end
         gsm_meas_pkg::GSM_MEAS: begin
            if (core_rsp_in.meas_done) begin
               r_next.result = core_rsp_in.result;
               r_next.ready = 1'b1;
               r_next.tick_cnt = 26'h0;
               r_next.sec_cnt = 12'h0;
               if (mode_next == `GSM_MODE_CONT) begin
                  r_next.st = gsm_meas_pkg::GSM_WAIT;
               end else begin
                  r_next.st = gsm_meas_pkg::GSM_IDLE;
               end
               if (mode_next == `GSM_MODE_SINGLE) begin
                  r_next.cfg[`GSM_MODE_MSB:`GSM_MODE_LSB] = `GSM_MODE_IDLE;
               end
            end
         end
         gsm_meas_pkg::GSM_WAIT: begin
            if (mode_next != `GSM_MODE_CONT) begin
               r_next.st = gsm_meas_pkg::GSM_IDLE;
            end else if (r_reg.tick_cnt == 26'(CLK_HZ - 1)) begin
               r_next.tick_cnt = 26'h0;
               if (r_reg.sec_cnt == r_reg.period - 12'h1) begin
                  r_next.meas_start = 1'b1;
                  r_next.st = gsm_meas_pkg::GSM_MEAS;
               end else begin
                  r_next.sec_cnt = r_reg.sec_cnt + 12'h1;
               end
            end else begin
               r_next.tick_cnt = r_reg.tick_cnt + 26'h1;
            end
         end
         default: r_next.st = gsm_meas_pkg::GSM_IDLE;
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         r_reg.st <= gsm_meas_pkg::GSM_IDLE;
         r_reg.cfg <= `GSM_RST_MEAS_CONFIG;
         r_reg.rate_h <= `GSM_RST_RATE_HIGH;
         r_reg.rate_l <= `GSM_RST_RATE_LOW;
         r_reg.period <= {`GSM_RST_RATE_HIGH, `GSM_RST_RATE_LOW};
         r_reg.sec_cnt <= 12'h0;
         r_reg.tick_cnt <= 26'h0;
         r_reg.result <= `GSM_RST_RESULT;
         r_reg.ready <= 1'b0;
         r_reg.offset <= `GSM_RST_OFFSET;
         r_reg.rdata <= 8'h00;
         r_reg.meas_start <= 1'b0;
         r_reg.comp_force <= 1'b0;
         r_reg.auto_en <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign host_rdata_out = r_reg.rdata;
   assign meas_start_out = r_reg.meas_start;
   assign comp_force_out = r_reg.comp_force;
   assign auto_comp_en_out = r_reg.auto_en;
   assign offset_out = r_reg.offset;
   assign period_out = r_reg.period;

endmodule

// ===== test/gsm_meas_ctrl_sva.sv
module gsm_meas_ctrl_sva #(parameter int CLK_HZ = 50000000) (
   // Clock, reset and host port
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire gsm_meas_pkg::gsm_host_req_s host_req_in,
   input wire logic [7:0] host_rdata_out,
   // Measurement core
   input wire gsm_meas_pkg::gsm_core_rsp_s core_rsp_in,
   input wire logic meas_start_out,
   input wire logic comp_force_out,
   input wire logic auto_comp_en_out,
   input wire logic [15:0] offset_out,
   input wire logic [11:0] period_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy;
   logic rdy;
   logic [15:0] res;
   wire wcfg = host_req_in.wr && host_req_in.addr == 8'h04;
   wire rds = host_req_in.rd && host_req_in.addr == 8'h07;
   wire done = core_rsp_in.meas_done && busy;
   // Shadow flag and result, so reads are judged without seeing inside.
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy <= 1'b0;
         rdy <= 1'b0;
         res <= 16'h0000;
      end else begin
         busy <= meas_start_out || (busy && !core_rsp_in.meas_done);
         rdy <= done || (rdy && !(host_req_in.rd && host_req_in.addr == 8'h06));
         if (done) begin
            res <= core_rsp_in.result;
         end
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   property p_auto; wcfg && host_req_in.wdata[3:2] == 2'h0 |=> !auto_comp_en_out; endproperty
   a_auto: assert property (p_auto) else $error("comp not off");
   property p_offs; auto_comp_en_out && core_rsp_in.offset_valid |=> offset_out == $past(core_rsp_in.offset); endproperty
   a_offs: assert property (p_offs) else $error("offset not kept");
   property p_force; wcfg && host_req_in.wdata[3:2] == 2'h2 |=> comp_force_out; endproperty
   a_force: assert property (p_force) else $error("no force pulse");
   property p_start; wcfg && host_req_in.wdata[1:0] == 2'h1 && !busy |-> ##[1:3] meas_start_out; endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_rate; host_req_in.wr && host_req_in.addr[7:1] == 7'h01 |=> $stable(period_out); endproperty
   a_rate: assert property (p_rate) else $error("period moved");
   property p_res; host_req_in.rd && host_req_in.addr inside {8'h05, 8'h06}
      |=> host_rdata_out == ($past(host_req_in.addr[0]) ? $past(res[15:8]) : $past(res[7:0])); endproperty
   a_res: assert property (p_res) else $error("bad result byte");
   property p_rdy; rds |=> host_rdata_out[4] == $past(rdy); endproperty
   a_rdy: assert property (p_rdy) else $error("bad ready flag");
   property p_top; rds |=> host_rdata_out[7:6] == 2'h0; endproperty
   a_top: assert property (p_top) else $error("status top set");
endmodule

bind gsm_meas_ctrl gsm_meas_ctrl_sva #(.CLK_HZ(CLK_HZ)) i_gsm_meas_ctrl_sva (.ref_clk_in(ref_clk_in),
   .rst_in(rst_in), .host_req_in(host_req_in), .host_rdata_out(host_rdata_out), .core_rsp_in(core_rsp_in),
   .meas_start_out(meas_start_out), .comp_force_out(comp_force_out), .auto_comp_en_out(auto_comp_en_out),
   .offset_out(offset_out), .period_out(period_out));

// ===== test/gsm_core_model.sv
module gsm_core_model (
   // Clock and block controls
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic meas_start_in,
   input wire logic comp_force_in,
   // Bench knobs
   input wire logic [7:0] delay_in,
   input wire logic [15:0] value_in,
   input wire logic ofs_in,
   // Answer
   output gsm_meas_pkg::gsm_core_rsp_s rsp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] m_cnt;
   logic [1:0] c_cnt;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         m_cnt <= 8'h00;
         c_cnt <= 2'h0;
      end else begin
         m_cnt <= meas_start_in ? delay_in : m_cnt - {7'h00, m_cnt != 8'h00};
         c_cnt <= comp_force_in ? 2'h3 : c_cnt - {1'b0, c_cnt != 2'h0};
      end
   end
   // Result shows the inverse outside its pulse, offset shows it inside its pulse, so a stale capture is caught.
   assign rsp_out.meas_done = m_cnt == 8'h01;
   assign rsp_out.result = rsp_out.meas_done ? value_in : ~value_in;
   assign rsp_out.comp_done = c_cnt == 2'h1;
   assign rsp_out.offset_valid = rsp_out.comp_done || ofs_in;
   assign rsp_out.offset = rsp_out.offset_valid ? ~value_in : value_in;
endmodule

// ===== test/gsm_meas_ctrl_tb_top.sv
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", n, e, s); end end
module gsm_meas_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ofs = 1'b0;
   gsm_meas_pkg::gsm_host_req_s req = '0;
   gsm_meas_pkg::gsm_core_rsp_s rsp;
   logic [7:0] rdata;
   logic start;
   logic force_p;
   logic auto_en;
   logic [15:0] offset;
   logic [11:0] period;
   logic [15:0] val = 16'h8123;
   int n_fail = 0;
   int n_tests = 0;
   always #10 ref_clk_in = ~ref_clk_in;
   gsm_meas_ctrl #(.CLK_HZ(10)) i_gsm_meas_ctrl (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .host_req_in(req),
      .host_rdata_out(rdata), .core_rsp_in(rsp), .meas_start_out(start), .comp_force_out(force_p),
      .auto_comp_en_out(auto_en), .offset_out(offset), .period_out(period));
   gsm_core_model i_gsm_core_model (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .meas_start_in(start),
      .comp_force_in(force_p), .delay_in(8'h05), .value_in(val), .ofs_in(ofs), .rsp_out(rsp));
   // --------------------------------
   // Host access and scenarios
   // --------------------------------
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge ref_clk_in);
      req <= '0;
      #1;
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      `CHK(n, e, rdata)
   endtask
   task automatic count(input int cyc, output int n);
      n = 0;
      repeat (cyc) begin
         n += start;
         @(posedge ref_clk_in);
         #1;
      end
   endtask
   task automatic t_single;
      int n;
      acc(1'b1, 8'h04, 8'h25);
      count(20, n);
      `CHK("starts", 1, n)
      rdc("mode", 8'h04, 8'h24);
      rdc("rdy", 8'h07, 8'h10);
      rdc("high", 8'h05, 8'h81);
      rdc("keep", 8'h07, 8'h10);
      rdc("low", 8'h06, 8'h23);
      rdc("clr", 8'h07, 8'h00);
      acc(1'b1, 8'h07, 8'hFF);
      acc(1'b1, 8'h05, 8'hAA);
      rdc("ro", 8'h07, 8'h00);
      rdc("rohi", 8'h05, 8'h81);
   endtask
   task automatic t_cont;
      int n;
      acc(1'b1, 8'h03, 8'h02);
      `CHK("hold", 12'h03C, period)
      acc(1'b1, 8'h04, 8'h06);
      count(150, n);
      `CHK("period", 12'h005, period)
      `CHK("repeat", 1'b1, n >= 2)
      acc(1'b1, 8'h04, 8'h07); // Select stays 01; 11 is never sent.
      count(150, n);
      `CHK("stop", 0, n)
   endtask
   task automatic t_comp;
      int n;
      acc(1'b1, 8'h04, 8'h08);
      `CHK("force", 1'b1, force_p)
      count(6, n);
      rdc("auto", 8'h04, 8'h04);
      `CHK("offset", 16'h7EDC, offset)
      acc(1'b1, 8'h04, 8'h00);
      `CHK("off", 1'b0, auto_en)
      @(posedge ref_clk_in);
      val <= 16'h1234;
      ofs <= 1'b1;
      @(posedge ref_clk_in);
      ofs <= 1'b0;
      count(2, n);
      `CHK("kept", 16'h7EDC, offset)
   endtask
   task automatic test_done;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rdc("cfg", 8'h04, 8'h24);
      rdc("gap", 8'h10, 8'h00);
      `CHK("rst", 12'h03C, period)
      t_single();
      t_cont();
      t_comp();
      test_done();
   end
   // A hang would otherwise run forever; the span covers all scenarios more than five times over.
   initial begin
      repeat (2000) @(posedge ref_clk_in);
      n_fail++;
      test_done();
   end
endmodule
